/* File: dfsf_flags.sv */
// Summary of operation
// - full/input-ready high while a location is free
// - writes ignored while full/input-ready low
// - full/input-ready timed by writing clock
// - every accepted write advances write pointer
// - freed location seen at second write edge
// - read counted only after full skew
// - output register word not counted as fill
// - fall-through loads first word unrequested
// - mode picks ready or empty meaning of the read-side flag; full/input-ready same in both
// - each queue holds empty and full offsets
// - offsets preset at reset, programmable from bus
// - almost-empty high above X words, read clock
// - almost-empty rises second read edge after write
// - write counted only after partial skew
// - almost-full low at depth minus Y
// - almost-full high at depth minus Y+1
// - almost-full rises second write edge after read
// - read counted only after partial skew
// - fill comparator resolves full, full-1, full-2
// - empty: reads ignored, output word held
// - fall-through ready and load on third edge
// - standard empty rises second edge, explicit read
// - crossings pass two flip-flop stages
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// one queue with its four flags
// ----------------------------------------
module dfsf_fifo
	import dfsf_pkg::*;
#(
	parameter int WIDTH = DATA_W_DEF,
	parameter int DEPTH = DEPTH_DEF
)(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// configuration
	input  wire logic             fall_through_mode,
	input  wire logic [OFS_W-1:0] empty_ofs,
	input  wire logic [OFS_W-1:0] full_ofs,
	// writing side
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  full_ir,
	output logic                  almost_full_n,
	// reading side
	input  wire logic             rd_en,
	output logic [WIDTH-1:0]      rd_data,
	output logic                  empty_or,
	output logic                  almost_empty_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	typedef logic [PW-1:0] dfsf_ptr_t;

	// queue state apart from the storage array
	typedef struct packed {
		dfsf_ptr_t        wptr;      // binary write pointer
		dfsf_ptr_t        wgray;     // gray copy sent to reader
		dfsf_ptr_t        rsync1;    // reader gray, first stage
		dfsf_ptr_t        rsync2;    // reader gray, second stage
		dfsf_ptr_t        rptr;      // binary read pointer
		dfsf_ptr_t        rgray;     // gray copy sent to writer
		dfsf_ptr_t        wsync1;    // writer gray, first stage
		dfsf_ptr_t        wsync2;    // writer gray, second stage
		logic             out_valid; // output register holds a new word
		logic [WIDTH-1:0] dout;      // output register
	} dfsf_fifo_st_t;

	function automatic dfsf_ptr_t bin2gray(input dfsf_ptr_t b);
		return b ^ (b >> 1);
	endfunction

	function automatic dfsf_ptr_t gray2bin(input dfsf_ptr_t g);
		dfsf_ptr_t b;
		b = g;
		for (int i = PW - 2; i >= 0; i--)
		begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	logic [WIDTH-1:0] mem [DEPTH];   // queue storage
	dfsf_fifo_st_t    s_r;           // registered state
	dfsf_fifo_st_t    s_nxt;         // next state
	dfsf_ptr_t        wfill;         // fill as the writer sees it
	dfsf_ptr_t        rcount;        // fill as the reader sees it
	logic             wr_take;       // write accepted this cycle
	logic             load_out;      // word moves to output register

	// ----------------------------------------
	// flags and next state
	// ----------------------------------------
	always_comb
	begin
		// fill counts exclude the output register word
		wfill  = s_r.wptr - gray2bin(s_r.rsync2);
		rcount = gray2bin(s_r.wsync2) - s_r.rptr;
		// full only when every slot is taken
		full_ir = (wfill != dfsf_ptr_t'(DEPTH));
		// partial flags from the same counts
		almost_full_n  = (int'(wfill) + int'(full_ofs)) < DEPTH;
		almost_empty_n = int'(rcount) > int'(empty_ofs);
		wr_take = wr_en && full_ir;
		// mode selects the meaning of the read-side flag
		if (fall_through_mode)
		begin
			empty_or = s_r.out_valid;
			load_out = (rcount != '0) && (!s_r.out_valid || rd_en);
		end
		else
		begin
			empty_or = (rcount != '0);
			load_out = rd_en && (rcount != '0);
		end
		rd_data = s_r.dout;
		s_nxt = s_r;
		// writer pointer, gray copy moves with it
		if (wr_take)
		begin
			s_nxt.wptr  = s_r.wptr + dfsf_ptr_t'(1);
			s_nxt.wgray = bin2gray(s_r.wptr + dfsf_ptr_t'(1));
		end
		// reader side: load or drain the output register
		if (load_out)
		begin
			s_nxt.dout      = mem[s_r.rptr[AW-1:0]];
			s_nxt.rptr      = s_r.rptr + dfsf_ptr_t'(1);
			s_nxt.rgray     = bin2gray(s_r.rptr + dfsf_ptr_t'(1));
			s_nxt.out_valid = fall_through_mode;
		end
		else if (fall_through_mode && rd_en && s_r.out_valid)
		begin
			s_nxt.out_valid = 1'b0;   // last word taken, dout held
		end
		else if (!fall_through_mode)
		begin
			s_nxt.out_valid = 1'b0;
		end
		// two-stage crossings; inputs settle a full period early, so
		// the edge after an event always begins its first sync cycle
		s_nxt.rsync1 = s_r.rgray;
		s_nxt.rsync2 = s_r.rsync1;
		s_nxt.wsync1 = s_r.wgray;
		s_nxt.wsync2 = s_r.wsync1;
	end

	// state register
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// storage write; refused writes never touch memory
	always_ff @(posedge core_clk)
	begin
		if (wr_take)
		begin
			mem[s_r.wptr[AW-1:0]] <= wr_data;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_wr_refused;
		wr_en && !full_ir;
	endsequence

	sequence s_wr_taken;
		wr_en && full_ir;
	endsequence

	a_refused_write: assert property (@(posedge core_clk) disable iff (rst)
		s_wr_refused |=> $stable(s_r.wptr))
		else $error("write taken while full");

	a_write_advance: assert property (@(posedge core_clk) disable iff (rst)
		s_wr_taken |=> s_r.wptr == $past(s_r.wptr) + dfsf_ptr_t'(1))
		else $error("write pointer did not advance");

	a_full_rise_late: assert property (@(posedge core_clk) disable iff (rst)
		$rose(full_ir) |-> $past(load_out, 3))
		else $error("input ready rose off the two-edge timing");

	// an offset reprogrammed from the bus moves the flag at once; only
	// fill-driven rises carry the two-edge latency
	a_ae_rise_late: assert property (@(posedge core_clk) disable iff (rst)
		$rose(almost_empty_n) && $stable(empty_ofs) |-> $past(wr_take, 3))
		else $error("almost-empty rose off the two-edge timing");

	a_af_rise_late: assert property (@(posedge core_clk) disable iff (rst)
		$rose(almost_full_n) && $stable(full_ofs) |-> $past(load_out, 3))
		else $error("almost-full rose off the two-edge timing");

	a_empty_holds_out: assert property (@(posedge core_clk) disable iff (rst)
		// the fall-through load is not a read and may coincide with one
		rd_en && !empty_or && !(fall_through_mode && rcount != '0) |=> $stable(rd_data))
		else $error("output changed on ignored read");

	a_fall_through_mode_first_load: assert property (@(posedge core_clk) disable iff (rst)
		fall_through_mode && $past(fall_through_mode, 4) && $rose(empty_or) |->
			$past(wr_take, 4) && $changed(s_r.rptr))
		else $error("fall-through load not on third edge");

	a_std_no_autoload: assert property (@(posedge core_clk) disable iff (rst)
		!fall_through_mode && !rd_en |=> $stable(rd_data) && $stable(s_r.rptr))
		else $error("standard mode moved data without read");

	a_fill_bound: assert property (@(posedge core_clk) disable iff (rst)
		int'(wfill) <= DEPTH && int'(rcount) <= DEPTH)
		else $error("fill count out of range");

	a_gray_one_bit: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(s_r.rgray ^ $past(s_r.rgray)) && $onehot0(s_r.wgray ^ $past(s_r.wgray)))
		else $error("crossing pointer moved more than one bit");
endmodule

// ----------------------------------------
// top: two queues and the bus registers
// ----------------------------------------
module dfsf_flags
	import dfsf_pkg::*;
#(
	parameter int WIDTH = DATA_W_DEF,
	parameter int DEPTH = DEPTH_DEF
)(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic [31:0]           wb_dat_o,
	output logic                  wb_ack_o,
	// wide port: writes queue 1, reads queue 2
	input  wire logic             wide_wr_en,
	input  wire logic [WIDTH-1:0] wide_wr_data,
	input  wire logic             wide_rd_en,
	output logic [WIDTH-1:0]      wide_rd_data,
	output logic                  wide_port_empty_or_ready,
	output logic                  wide_port_full_or_input_ready,
	output logic                  fifo2_almost_empty_n,
	output logic                  fifo1_almost_full_n,
	// transmit port: reads queue 1
	input  wire logic             tx_rd_en,
	output logic [WIDTH-1:0]      tx_rd_data,
	output logic                  tx_port_empty_or_ready,
	output logic                  fifo1_almost_empty_n,
	// receive port: writes queue 2
	input  wire logic             rx_wr_en,
	input  wire logic [WIDTH-1:0] rx_wr_data,
	output logic                  rx_port_full_or_input_ready,
	output logic                  fifo2_almost_full_n
);
	// refuse sizes the pointer and offset logic cannot serve
	if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("DEPTH must be a power of two from 4 to 1024");
	end
	if (WIDTH < 1 || FULL_EMPTY_SKEW_CYC > 1 || PARTIAL_FLAG_SKEW_CYC > 1)
	begin : g_bad_cfg
		$error("width or skew figures not servable");
	end

	dfsf_regs_t        r_r;        // register state
	dfsf_regs_t        r_nxt;      // next register state
	logic [STAT_W-1:0] status;     // live flags for readback
	logic              bus_req;    // request present, not yet answered
	logic              bus_wr;     // write lands on this edge
	logic [31:0]       cur;        // current value at the address
	logic [31:0]       merged;     // value after byte lanes

	// ----------------------------------------
	// queue 1: wide port to transmit port
	// ----------------------------------------
	dfsf_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo1 (
		.core_clk       (core_clk),
		.rst            (rst),
		.fall_through_mode           (r_r.fall_through_mode),
		.empty_ofs      (r_r.f1_x),
		.full_ofs       (r_r.f1_y),
		.wr_en          (wide_wr_en),
		.wr_data        (wide_wr_data),
		.full_ir        (wide_port_full_or_input_ready),
		.almost_full_n  (fifo1_almost_full_n),
		.rd_en          (tx_rd_en),
		.rd_data        (tx_rd_data),
		.empty_or       (tx_port_empty_or_ready),
		.almost_empty_n (fifo1_almost_empty_n)
	);

	// ----------------------------------------
	// queue 2: receive port to wide port
	// ----------------------------------------
	dfsf_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo2 (
		.core_clk       (core_clk),
		.rst            (rst),
		.fall_through_mode           (r_r.fall_through_mode),
		.empty_ofs      (r_r.f2_x),
		.full_ofs       (r_r.f2_y),
		.wr_en          (rx_wr_en),
		.wr_data        (rx_wr_data),
		.full_ir        (rx_port_full_or_input_ready),
		.almost_full_n  (fifo2_almost_full_n),
		.rd_en          (wide_rd_en),
		.rd_data        (wide_rd_data),
		.empty_or       (wide_port_empty_or_ready),
		.almost_empty_n (fifo2_almost_empty_n)
	);

	// ----------------------------------------
	// bus decode and register update
	// ----------------------------------------
	always_comb
	begin
		status = {fifo2_almost_full_n, rx_port_full_or_input_ready,
			fifo1_almost_empty_n, tx_port_empty_or_ready,
			fifo1_almost_full_n, wide_port_full_or_input_ready,
			fifo2_almost_empty_n, wide_port_empty_or_ready};
		// unmapped addresses read zero
		case (wb_adr_i)
			REG_CTRL:     cur = {31'h0, r_r.fall_through_mode};
			REG_F1_EMPTY: cur = {22'h0, r_r.f1_x};
			REG_F1_FULL:  cur = {22'h0, r_r.f1_y};
			REG_F2_EMPTY: cur = {22'h0, r_r.f2_x};
			REG_F2_FULL:  cur = {22'h0, r_r.f2_y};
			REG_STATUS:   cur = {24'h0, status};
			default:      cur = 32'h0;
		endcase
		merged  = dfsf_sel_merge(cur, wb_dat_i, wb_sel_i);
		bus_req = wb_cyc_i && wb_stb_i && !r_r.ack;
		// write lands on the edge where the master sees ack
		bus_wr  = wb_cyc_i && wb_stb_i && r_r.ack && wb_we_i;
		r_nxt = r_r;
		r_nxt.ack = bus_req;
		if (bus_req)
		begin
			r_nxt.rdata = wb_we_i ? 32'h0 : cur;
		end
		// offsets programmed from the bus; mode change affects
		// both queues at once, best done while they are idle
		if (bus_wr)
		begin
			case (wb_adr_i)
				REG_CTRL:     r_nxt.fall_through_mode = merged[CTRL_FALL_THROUGH_MODE_BIT];
				REG_F1_EMPTY: r_nxt.f1_x = merged[OFS_W-1:0];
				REG_F1_FULL:  r_nxt.f1_y = merged[OFS_W-1:0];
				REG_F2_EMPTY: r_nxt.f2_x = merged[OFS_W-1:0];
				REG_F2_FULL:  r_nxt.f2_y = merged[OFS_W-1:0];
				default:      r_nxt.fall_through_mode = r_r.fall_through_mode;  // read-only or unmapped
			endcase
		end
		wb_ack_o = r_r.ack;
		wb_dat_o = r_r.rdata;
	end

	// register state; reset loads the offset presets
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			r_r       <= '0;
			r_r.fall_through_mode  <= FALL_THROUGH_MODE_RST;
			r_r.f1_x  <= OFFSET_PRESET;
			r_r.f1_y  <= OFFSET_PRESET;
			r_r.f2_x  <= OFFSET_PRESET;
			r_r.f2_y  <= OFFSET_PRESET;
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	a_offset_preset: assert property (@(posedge core_clk)
		$past(rst) |-> r_r.f1_x == OFFSET_PRESET && r_r.f2_y == OFFSET_PRESET)
		else $error("offsets not preset after reset");
endmodule
`default_nettype wire

/* File: dfsf_pkg.sv */
`default_nettype none
package dfsf_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int DATA_W_DEF = 36;   // long word width of both queues
	localparam int DEPTH_DEF  = 1024; // largest variant; 256 and 512 also legal
	localparam int OFS_W      = 10;   // offset field width, serves up to 1024
	localparam int DEPTH_MAX  = 1024;
	localparam int DEPTH_MIN  = 4;
	localparam int SYNC_STAGES = 2;   // flops on every pointer crossing

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [OFS_W-1:0] OFFSET_PRESET = 10'h008;
	localparam logic             FALL_THROUGH_MODE_RST      = 1'b0;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam int          ADR_W          = 8;
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_F1_EMPTY   = 8'h04;
	localparam logic [7:0]  REG_F1_FULL    = 8'h08;
	localparam logic [7:0]  REG_F2_EMPTY   = 8'h0c;
	localparam logic [7:0]  REG_F2_FULL    = 8'h10;
	localparam logic [7:0]  REG_STATUS     = 8'h14;
	localparam int          CTRL_FALL_THROUGH_MODE_BIT  = 0;
	localparam int          STAT_W         = 8;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int FULL_EMPTY_SYNC_SKEW_NS   = 5; // plain default
	localparam int PARTIAL_FLAG_SYNC_SKEW_NS = 5; // plain default
	localparam int FULL_EMPTY_SKEW_CYC =
		(FULL_EMPTY_SYNC_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARTIAL_FLAG_SKEW_CYC =
		(PARTIAL_FLAG_SYNC_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// register state carried as one struct
	// ----------------------------------------
	typedef struct packed {
		logic             fall_through_mode;    // fall_through_mode
		logic [OFS_W-1:0] f1_x;    // fifo1_empty_offset
		logic [OFS_W-1:0] f1_y;    // fifo1_full_offset
		logic [OFS_W-1:0] f2_x;    // fifo2_empty_offset
		logic [OFS_W-1:0] f2_y;    // fifo2_full_offset
		logic             ack;     // bus answer
		logic [31:0]      rdata;   // bus read data
	} dfsf_regs_t;

	// byte-lane merge of a bus write onto an old value
	function automatic logic [31:0] dfsf_sel_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction
endpackage
`default_nettype wire

/* File: dfsf_rd_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// transmit-port reader model
// ----------------------------------------
module dfsf_rd_model
	import dfsf_pkg::*;
#(
	parameter int WIDTH = DATA_W_DEF
)(
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// bench request, one read per cycle held
	input  wire logic             go,
	// queue read side
	input  wire logic             ready,
	input  wire logic [WIDTH-1:0] data,
	output logic                  rd_en,
	// words that came back
	output logic [3:0]            n_got,
	output logic [WIDTH-1:0]      word_r [8]
);
	logic pend_r; // taken read waits for its word

	// strobe changes just after an edge; the reader does not look at
	// the flag first, so reads on an empty queue really reach the device
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rd_en  <= 1'b0;
			pend_r <= 1'b0;
			n_got  <= 4'h0;
		end
		else
		begin
			rd_en  <= go;
			pend_r <= rd_en & ready;
			// standard timing: word lands one cycle after the read
			if (pend_r)
			begin
				word_r[n_got[2:0]] <= data;
				n_got              <= n_got + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
	import dfsf_pkg::*;
	localparam int W = 36;
	localparam int D = 4; // small depth so fills are quick
	logic          core_clk, rst, go;
	logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]    wb_adr_i;
	logic [3:0]    wb_sel_i, n_got;
	logic [31:0]   wb_dat_i, wb_dat_o;
	logic          wide_wr_en, wide_rd_en, tx_rd_en, rx_wr_en;
	logic [W-1:0]  wide_wr_data, wide_rd_data, tx_rd_data, rx_wr_data;
	logic          w_ready, w_space, f2_ae, f1_af, tx_ready, f1_ae, rx_space, f2_af;
	logic [W-1:0]  words [8];
	int            err_total, comparisons;

	dfsf_flags #(.WIDTH(W), .DEPTH(D)) dut (
		.core_clk(core_clk), .rst(rst),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wide_wr_en(wide_wr_en), .wide_wr_data(wide_wr_data),
		.wide_rd_en(wide_rd_en), .wide_rd_data(wide_rd_data),
		.wide_port_empty_or_ready(w_ready), .wide_port_full_or_input_ready(w_space),
		.fifo2_almost_empty_n(f2_ae), .fifo1_almost_full_n(f1_af),
		.tx_rd_en(tx_rd_en), .tx_rd_data(tx_rd_data),
		.tx_port_empty_or_ready(tx_ready), .fifo1_almost_empty_n(f1_ae),
		.rx_wr_en(rx_wr_en), .rx_wr_data(rx_wr_data),
		.rx_port_full_or_input_ready(rx_space), .fifo2_almost_full_n(f2_af)
	);

	// far side of the transmit port
	dfsf_rd_model #(.WIDTH(W)) reader (
		.core_clk(core_clk), .rst(rst), .go(go), .ready(tx_ready),
		.data(tx_rd_data), .rd_en(tx_rd_en), .n_got(n_got), .word_r(words)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// lets n edges pass, then settles past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// classic single cycle; ack sampled at the edge, request held till then
	task automatic wb_cycle(input logic we, input logic [7:0] adr,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= wd;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// one write strobe; returns just after the taking edge
	task automatic push(input logic rxp, input logic [W-1:0] d);
		@(posedge core_clk);
		if (rxp)
		begin
			rx_wr_en   <= 1'b1;
			rx_wr_data <= d;
		end
		else
		begin
			wide_wr_en   <= 1'b1;
			wide_wr_data <= d;
		end
		@(posedge core_clk);
		rx_wr_en   <= 1'b0;
		wide_wr_en <= 1'b0;
		#1;
	endtask

	// one reader request; returns just after the taking edge
	task automatic pop1;
		@(posedge core_clk);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		tick(1);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_reset;
		logic [31:0] rd;
		tick(1);
		chk(tx_ready, 0);
		chk(w_space, 1);
		chk(f1_af, (8 < D));
		chk(rx_space, 1);
		wb_cycle(1'b0, REG_F2_FULL, 32'h0, rd);
		chk(rd, 8);
		wb_cycle(1'b1, REG_STATUS, 32'hff, rd);
		wb_cycle(1'b0, REG_STATUS, 32'h0, rd);
		chk(rd, 32'h44);
		wb_cycle(1'b0, 8'h18, 32'h0, rd);
		chk(rd, 0);
	endtask

	// standard mode, queue 1 filled to the brim then drained
	task automatic test_std_fill;
		logic [31:0] rd;
		wb_cycle(1'b1, REG_F1_EMPTY, 32'h1, rd);
		wb_cycle(1'b1, REG_F1_FULL, 32'h1, rd);
		wb_cycle(1'b0, REG_F1_EMPTY, 32'h0, rd);
		chk(rd, 1);
		tick(1);
		chk(f1_af, 1);
		push(1'b0, 36'h0a0);
		tick(1);
		chk(tx_ready, 0);
		tick(1);
		chk(tx_ready, 1);
		chk(f1_ae, 0);
		push(1'b0, 36'h0a1);
		tick(1);
		chk(f1_ae, 0);
		tick(1);
		chk(f1_ae, 1);
		push(1'b0, 36'h0a2);
		chk(f1_af, 0);
		chk(w_space, 1);
		push(1'b0, 36'h0a3);
		chk(w_space, 0);
		push(1'b0, 36'hbad);
		chk(w_space, 0);
		pop1;
		tick(1);
		chk(w_space, 0);
		tick(1);
		chk(w_space, 1);
		chk(f1_af, 0);
		pop1;
		tick(1);
		chk(f1_af, 0);
		tick(1);
		chk(f1_af, 1);
		pop1;
		pop1;
		tick(2);
		chk(tx_ready, 0);
		pop1;
		tick(2);
		chk(n_got, 4);
		chk(tx_rd_data, 36'h0a3);
		for (int i = 0; i < 4; i++)
			chk(words[i], 36'h0a0 + i);
	endtask

	// fall-through mode on queue 2: unrequested load, output word not counted
	task automatic test_fall_through_mode;
		logic [31:0] rd;
		wb_cycle(1'b1, REG_CTRL, 32'h1, rd);
		push(1'b1, 36'h0b0);
		tick(1);
		chk(w_ready, 0);
		tick(1);
		chk(w_ready, 0);
		tick(1);
		chk(w_ready, 1);
		chk(wide_rd_data, 36'h0b0);
		for (int i = 1; i <= D; i++)
		begin
			chk(rx_space, 1);
			push(1'b1, 36'h0b0 + i);
		end
		chk(rx_space, 0);
		@(posedge core_clk);
		wide_rd_en <= 1'b1;
		@(posedge core_clk);
		wide_rd_en <= 1'b0;
		tick(1);
		chk(wide_rd_data, 36'h0b1);
		chk(w_ready, 1);
	endtask

	// ----------------------------------------
	// verdict, clock, watchdog, main sequence
	// ----------------------------------------
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// 100 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// whole run needs under a hundred cycles
	initial
	begin
		repeat (3000) @(posedge core_clk);
		err_total++;
		stop_test;
	end

	initial
	begin
		err_total    = 0;
		comparisons  = 0;
		rst          = 1'b1;
		go           = 1'b0;
		wb_cyc_i     = 1'b0;
		wb_stb_i     = 1'b0;
		wb_we_i      = 1'b0;
		wb_adr_i     = 8'h00;
		wb_sel_i     = 4'h0;
		wb_dat_i     = 32'h0;
		wide_wr_en   = 1'b0;
		wide_rd_en   = 1'b0;
		rx_wr_en     = 1'b0;
		wide_wr_data = '0;
		rx_wr_data   = '0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		test_reset;
		test_std_fill;
		test_fall_through_mode;
		stop_test;
	end
endmodule

`default_nettype wire
